/* File: verilog/timer_core.sv */
/*
  timer module common core: 10-bit counter, comparators a and p,
  capture, compare output, pwm and single pulse, axi4-lite registers.
  assumes the tick inputs are one-cycle pulses on aclk and pins are async.
*/
// The address map and the AXI4-Lite slave port were left to the implementer.
// Overview of operation
// - counter clock picked by three-bit select
// - external clock counts on chosen edge
// - single pulse triggered by external clock pin
// - capture on rising, falling or both edges
// - compare match interrupts, clears, drives output
// - separate interrupts for comparators a and p
// - compare output goes high, low or toggles
// - pwm shares the compare output pin
// - one edge pwm channel, one single pulse
// - one select bit per shared pin
// - low bytes reached only through byte buffer
// - low compare write fills buffer only
// - high compare write also loads low byte
// - high byte read loads buffer with low
// - low byte read returns the buffer
// - 10-bit up counter, p sees top three
// - counter cleared when enabled, kept when stopped
// - p code gives 128-clock multiples, zero overflows
// - capture field codes rise, fall, both, none
`timescale 1ns/100ps
module timer_core
  import timer_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              high_clock_tick,
  input  wire logic              time_base_tick,
  input  wire logic              external_clock_pin,
  input  wire logic              capture_input_pin,
  output logic                   timer_output_pin,
  output logic                   timer_output_oe,
  output logic                   match_a_irq,
  output logic                   match_p_irq
);

  ctrl0_t            c0_r;                     // timer_control_first
  ctrl1_t            c1_r;                     // timer_control_second
  pinsel_t           psel_r;                   // pin selection
  logic [CNT_W-1:0]  cnt_r;                    // main counter
  logic [CNT_W-1:0]  compare_a_value_r;                   // compare_a_value
  logic [7:0]        buf_r;                    // shared low byte buffer
  logic [1:0]        stat_r;                   // sticky match flags
  logic              on_prev_r;                // last counter_on_bit
  logic              sp_r;                     // single pulse active
  logic [1:0]        div4_r;                   // system clock divider
  logic [5:0]        hdiv_r;                   // high clock divider
  logic [ADDR_W-1:0] wa_r;                     // held write address
  logic [31:0]       wd_r;                     // held write data
  logic [3:0]        ws_r;                     // held write strobes
  logic [1:0]        ext_rise;                 // synced pin rising edges
  logic [1:0]        ext_fall;                 // synced pin falling edges
  logic              tick;                     // selected counter clock
  logic              run;                      // counting tick
  logic              on_rise;                  // counter_on_bit went high
  logic              sp_trig;                  // single pulse launch
  logic              cap_ev;                   // capture event
  logic              match_a;                  // comparator a hit
  logic              match_p;                  // comparator p hit
  logic [CNT_W-1:0]  cnt_inc;                  // next count
  logic              wr_exec;                  // write performed now
  logic              rd_exec;                  // read performed now
  logic              pwm_act;                  // pwm waveform active phase

  // word select shared by read and write decoding
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[ADDR_W-1] == 1'b0);
  endfunction

  // pins pass two flops and an edge register first
  pin_edge_sync #(.N(2)) u_sync
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_async ({capture_input_pin, external_clock_pin}),
    .rise      (ext_rise),
    .fall      (ext_fall)
  );

  // counter clock source select
  always_comb
  begin
    case (c0_r.clk_sel)
      CLK_SYS4: tick = (div4_r == 2'(PSC_SYS - 1));
      CLK_SYS:  tick = 1'b1;
      CLK_H16:  tick = high_clock_tick && (hdiv_r[3:0] == 4'(PSC_H_LO - 1));
      CLK_H64:  tick = high_clock_tick && (hdiv_r == 6'(PSC_H_HI - 1));
      CLK_TB0,
      CLK_TB1:  tick = time_base_tick;
      CLK_EXTR: tick = psel_r.clk_en && ext_rise[0];
      CLK_EXTF: tick = psel_r.clk_en && ext_fall[0];
      default:  tick = 1'b0;
    endcase
  end

  // prescalers run free so ratios stay steady
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div4_r <= 2'h0;
      hdiv_r <= 6'h00;
    end
    else
    begin
      div4_r <= div4_r + 2'h1;
      if (high_clock_tick)
        hdiv_r <= hdiv_r + 6'h01;
    end
  end

  // match and event decode
  always_comb
  begin
    on_rise = c0_r.on && !on_prev_r;
    run     = tick && c0_r.on && !c0_r.pause;
    cnt_inc = cnt_r + 10'h001;
    // a match is seen as the counter reaches the value
    match_a = run && (cnt_inc == compare_a_value_r) && (c1_r.mode != MODE_CAP);
    // p code zero means full overflow, else 128-clock steps
    if (c0_r.cmp_p == 3'h0)
      match_p = run && (cnt_r == 10'h3FF);
    else
      match_p = run && (cnt_inc == {c0_r.cmp_p, 7'h00});
    sp_trig = (c1_r.mode == MODE_PWM) && (c1_r.pin_fn == 2'h3) && c0_r.on
              && psel_r.clk_en && ext_rise[0];
    case (c1_r.pin_fn)
      2'h0:    cap_ev = ext_rise[1];
      2'h1:    cap_ev = ext_fall[1];
      2'h2:    cap_ev = ext_rise[1] | ext_fall[1];
      default: cap_ev = 1'b0;
    endcase
    cap_ev  = cap_ev && psel_r.cap_en && c0_r.on && (c1_r.mode == MODE_CAP);
    pwm_act = (cnt_r < compare_a_value_r);
  end

  // main counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r     <= '0;
      on_prev_r <= 1'b0;
    end
    else
    begin
      on_prev_r <= c0_r.on;
      if (on_rise || sp_trig)
        cnt_r <= '0;
      else if (run)
      begin
        // clear source: a when cclr set, else p
        if (c1_r.cclr ? match_a : match_p)
          cnt_r <= '0;
        else
          cnt_r <= cnt_inc;
      end
    end
  end

  // single pulse window, closed by comparator a
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sp_r <= 1'b0;
    else if (sp_trig)
      sp_r <= 1'b1;
    else if (match_a || !c0_r.on)
      sp_r <= 1'b0;
  end

  // output pin level; pwm and compare share one pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_output_pin <= 1'b0;
      timer_output_oe  <= 1'b0;
    end
    else
    begin
      timer_output_oe <= psel_r.out_en;
      if (c1_r.mode == MODE_CMP)
      begin
        if (on_rise)
          timer_output_pin <= c1_r.out_init;
        else if (match_a)
        begin
          case (c1_r.pin_fn)
            2'h1:    timer_output_pin <= 1'b0;
            2'h2:    timer_output_pin <= 1'b1;
            2'h3:    timer_output_pin <= ~timer_output_pin;
            default: timer_output_pin <= timer_output_pin;
          endcase
        end
      end
      else if (c1_r.mode == MODE_PWM)
      begin
        // active level from out_init, pol inverts the pin
        case (c1_r.pin_fn)
          2'h0:    timer_output_pin <= ~c1_r.out_init ^ c1_r.pol;
          2'h1:    timer_output_pin <= c1_r.out_init ^ c1_r.pol;
          2'h2:    timer_output_pin <= ((pwm_act && c0_r.on) ~^ c1_r.out_init) ^ c1_r.pol;
          default: timer_output_pin <= (sp_r ~^ c1_r.out_init) ^ c1_r.pol;
        endcase
      end
      // timer and capture modes leave the pin as it is
    end
  end

  // two interrupt pulses plus sticky copies
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      match_a_irq <= 1'b0;
      match_p_irq <= 1'b0;
      stat_r      <= 2'h0;
    end
    else
    begin
      match_a_irq <= match_a || cap_ev;
      match_p_irq <= match_p;
      // set wins over a same-cycle clear
      stat_r <= (stat_r & ~((wr_exec && hit(wa_r, OFS_STATUS) && ws_r[0]) ? wd_r[1:0] : 2'h0))
                | {match_p, match_a || cap_ev};
    end
  end

  // axi write channels, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wa_r          <= '0;
      wd_r          <= 32'h0000_0000;
      ws_r          <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        wa_r          <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wd_r         <= s_axi_wdata;
        ws_r         <= s_axi_wstrb;
      end
      if (wr_exec)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wa_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_exec = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_exec = s_axi_arvalid && s_axi_arready;

  // control registers, lane 0 carries every field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c0_r   <= ctrl0_t'(CTRL0_RST);
      c1_r   <= ctrl1_t'(CTRL1_RST);
      psel_r <= pinsel_t'(PINSEL_RST);
    end
    else if (wr_exec && ws_r[0])
    begin
      if (hit(wa_r, OFS_CTRL0))
        c0_r <= ctrl0_t'(wd_r[7:0]);
      if (hit(wa_r, OFS_CTRL1))
        c1_r <= ctrl1_t'(wd_r[7:0]);
      if (hit(wa_r, OFS_PINSEL))
        psel_r <= pinsel_t'(wd_r[2:0]);
    end
  end

  // comparator a and byte buffer; write side wins the buffer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      compare_a_value_r <= '0;
      buf_r  <= 8'h00;
    end
    else
    begin
      if (cap_ev)
        compare_a_value_r <= cnt_r;
      else if (wr_exec && ws_r[0] && hit(wa_r, OFS_CMPA_HI))
        compare_a_value_r <= {wd_r[1:0], buf_r};
      if (wr_exec && ws_r[0] && hit(wa_r, OFS_CMPA_LO))
        buf_r <= wd_r[7:0];
      else if (rd_exec && hit(s_axi_araddr, OFS_CNT_HI))
        buf_r <= cnt_r[7:0];
      else if (rd_exec && hit(s_axi_araddr, OFS_CMPA_HI))
        buf_r <= compare_a_value_r[7:0];
    end
  end

  // axi read channel, data registered at the address edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (rd_exec)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata   <= 32'h0000_0000;
      if (hit(s_axi_araddr, OFS_CTRL0))
        s_axi_rdata[7:0] <= c0_r;
      else if (hit(s_axi_araddr, OFS_CTRL1))
        s_axi_rdata[7:0] <= c1_r;
      else if (hit(s_axi_araddr, OFS_CNT_LO) || hit(s_axi_araddr, OFS_CMPA_LO))
        s_axi_rdata[7:0] <= buf_r;
      else if (hit(s_axi_araddr, OFS_CNT_HI))
        s_axi_rdata[1:0] <= cnt_r[9:8];
      else if (hit(s_axi_araddr, OFS_CMPA_HI))
        s_axi_rdata[1:0] <= compare_a_value_r[9:8];
      else if (hit(s_axi_araddr, OFS_STATUS))
        s_axi_rdata[1:0] <= stat_r;
      else if (hit(s_axi_araddr, OFS_PINSEL))
        s_axi_rdata[2:0] <= psel_r;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ON_CLEAR: assert property (on_rise |=> cnt_r == '0)
    else $error("counter not cleared on enable");
  AST_OFF_HOLD: assert property (!c0_r.on && $past(!c0_r.on) |=> $stable(cnt_r))
    else $error("counter moved while off");
  AST_P_PERIOD: assert property (match_p && c0_r.cmp_p != 3'h0
    |-> cnt_r == {c0_r.cmp_p, 7'h00} - 10'h001)
    else $error("p match at wrong count");
  AST_A_IRQ: assert property (match_a |=> match_a_irq ##1 stat_r[STAT_A_BIT])
    else $error("a match lost");
  AST_P_IRQ: assert property (match_p |=> match_p_irq)
    else $error("p match lost");
  AST_CLR_A: assert property (match_a && c1_r.cclr && !sp_trig |=> cnt_r == '0)
    else $error("counter not cleared by a match");
  AST_TOGGLE: assert property (match_a && !on_rise && c1_r.mode == MODE_CMP
    && c1_r.pin_fn == 2'h3 |=> timer_output_pin != $past(timer_output_pin))
    else $error("output did not toggle");
  AST_LO_WRITE: assert property (wr_exec && hit(wa_r, OFS_CMPA_LO) && !cap_ev
    |=> $stable(compare_a_value_r))
    else $error("low write reached comparator");
  AST_HI_WRITE: assert property (wr_exec && ws_r[0] && hit(wa_r, OFS_CMPA_HI) && !cap_ev
    |=> compare_a_value_r[7:0] == $past(buf_r))
    else $error("buffer not moved to low byte");
  AST_HI_READ: assert property (rd_exec && hit(s_axi_araddr, OFS_CNT_HI) && !wr_exec
    |=> buf_r == $past(cnt_r[7:0]))
    else $error("buffer not loaded on high read");
  AST_LO_READ: assert property (rd_exec && hit(s_axi_araddr, OFS_CNT_LO)
    |=> s_axi_rdata[7:0] == $past(buf_r))
    else $error("low read not from buffer");
  AST_CAPTURE: assert property (cap_ev |=> compare_a_value_r == $past(cnt_r))
    else $error("capture value wrong");
  AST_BRESP: assert property (wr_exec |=> s_axi_bvalid)
    else $error("write response missing");

  COV_P_MATCH:  cover property (match_p ##[1:300] match_p);
  COV_CAPTURE:  cover property (cap_ev);
  COV_PULSE:    cover property (sp_trig ##[1:1000] !sp_r);
  COV_HI_LO_RD: cover property (rd_exec && hit(s_axi_araddr, OFS_CNT_HI)
    ##[1:20] rd_exec && hit(s_axi_araddr, OFS_CNT_LO));

endmodule // timer_core

/* File: verilog/timer_pkg.sv */
/*
  shared constants, field layouts and types of the timer core.
  assumes a 32-bit axi4-lite register bus with byte addresses.
*/
package timer_pkg;

  localparam int          ADDR_W      = 6;       // byte address width of the slave
  localparam int          CNT_W       = 10;      // main counter width
  localparam int          CMP_P_W     = 3;       // comparator p width (counter top bits)
  localparam int          P_LSB       = 7;       // lowest counter bit seen by comparator p
  localparam int          PSC_SYS     = 4;       // system clock ratio
  localparam int          PSC_H_LO    = 16;      // internal high clock first ratio
  localparam int          PSC_H_HI    = 64;      // internal high clock second ratio

  // register byte offsets
  localparam logic [5:0]  OFS_CTRL0   = 6'h00;   // timer_control_first
  localparam logic [5:0]  OFS_CTRL1   = 6'h04;   // timer_control_second
  localparam logic [5:0]  OFS_CNT_LO  = 6'h08;   // count_low_byte
  localparam logic [5:0]  OFS_CNT_HI  = 6'h0C;   // count_high_byte
  localparam logic [5:0]  OFS_CMPA_LO = 6'h10;   // match_a_low_byte
  localparam logic [5:0]  OFS_CMPA_HI = 6'h14;   // match_a_high_byte
  localparam logic [5:0]  OFS_STATUS  = 6'h18;   // sticky match flags, write one to clear
  localparam logic [5:0]  OFS_PINSEL  = 6'h1C;   // pin function selection bits

  // reset values
  localparam logic [7:0]  CTRL0_RST   = 8'h00;
  localparam logic [7:0]  CTRL1_RST   = 8'h00;
  localparam logic [2:0]  PINSEL_RST  = 3'h0;

  // status bit positions
  localparam int          STAT_A_BIT  = 0;
  localparam int          STAT_P_BIT  = 1;

  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CLK_SYS4 = 3'h0, CLK_SYS = 3'h1, CLK_H16 = 3'h2, CLK_H64 = 3'h3,
    CLK_TB0  = 3'h4, CLK_TB1 = 3'h5, CLK_EXTR = 3'h6, CLK_EXTF = 3'h7
  } clk_sel_t;

  typedef enum logic [1:0] {
    MODE_CMP = 2'h0, MODE_CAP = 2'h1, MODE_PWM = 2'h2, MODE_TMR = 2'h3
  } mode_t;

  typedef struct packed {
    logic                 pause;     // hold counter value
    clk_sel_t             clk_sel;   // counter_clock_select
    logic                 on;        // counter_on_bit
    logic [CMP_P_W-1:0]   cmp_p;     // compare_p_value
  } ctrl0_t;

  typedef struct packed {
    mode_t                mode;      // operating mode
    logic [1:0]           pin_fn;    // pin_function_field
    logic                 out_init;  // initial or active level
    logic                 pol;       // pwm output inversion
    logic                 dpx;       // stored only
    logic                 cclr;      // 1: clear on a match, 0: on p match
  } ctrl1_t;

  typedef struct packed {
    logic                 out_en;    // timer_output_pin serves the timer
    logic                 cap_en;    // capture_input_pin serves the timer
    logic                 clk_en;    // external_clock_pin serves the timer
  } pinsel_t;

endpackage

/* File: verilog/pin_edge_sync.sv */
/*
  two-flop synchronisers with registered edge detection for pins.
  assumes asynchronous pin levels and a single system clock.
*/
`timescale 1ns/100ps
module pin_edge_sync
#(
  parameter int N = 2                          // number of pins
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] pin_async,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_pin
      logic meta_r;                            // first stage, read by sync_r only
      logic sync_r;                            // second stage
      logic last_r;                            // previous synced level

      // sync chain and edge pulses
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_r     <= 1'b0;
          sync_r     <= 1'b0;
          last_r     <= 1'b0;
          rise[i]    <= 1'b0;
          fall[i]    <= 1'b0;
        end
        else
        begin
          meta_r     <= pin_async[i];
          sync_r     <= meta_r;
          last_r     <= sync_r;
          rise[i]    <= sync_r & ~last_r;
          fall[i]    <= ~sync_r & last_r;
        end
      end
    end
  endgenerate

endmodule // pin_edge_sync

/* File: verif/pin_partner.sv */
/*
  far side of the timer pins: external clock trains, capture level.
  assumes aclk shared with the bench; bench strobes burst.
*/
`timescale 1ns/100ps
module pin_partner
(
  input  wire logic       aclk,
  input  wire logic       burst,
  input  wire logic [3:0] n_pulse,
  input  wire logic       cap_lvl,
  output logic            ext_pin = 1'b0,
  output logic            cap_pin = 1'b0
);
  logic [7:0] ph_r = 8'h00; // phase, 16 cycles a pulse
  // slow pulses so every edge clears the pin synchroniser
  always @(posedge aclk)
  begin
    if (burst)
      ph_r <= {n_pulse, 4'h0};
    else if (ph_r != 8'h00)
      ph_r <= ph_r - 8'h01;
    ext_pin <= ph_r[3]; // idles low between trains
    cap_pin <= cap_lvl;
  end
endmodule // pin_partner

/* File: verif/timer_core_test.sv */
/*
  self-checking bench of timer_core over its bus and pins.
  assumes pin_partner on the pins and a 100 MHz aclk.
*/
`timescale 1ns/100ps
module timer_module_common_core_test
  import timer_pkg::*;
;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %0t %h %h", $time, g, e); end end
  logic              aclk = 1'b0, aresetn = 1'b0, burst = 1'b0, cap_lvl = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rd_d, p_gap;
  logic [31:0]       p_last = 32'h0, cyc = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'hF, n_pulse = 4'h0;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs_d;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic              high_clock_tick = 1'b0, time_base_tick = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, external_clock_pin, capture_input_pin;
  logic              timer_output_pin, timer_output_oe, match_a_irq, match_p_irq;
  int                n_fail = 0, cmp_count = 0, a_n = 0, p_n = 0, k = 0;
  // 10 ns clock
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  timer_core dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clock_tick, .time_base_tick,
    .external_clock_pin, .capture_input_pin, .timer_output_pin, .timer_output_oe,
    .match_a_irq, .match_p_irq
  );
  pin_partner far
  (
    .aclk, .burst, .n_pulse, .cap_lvl, .ext_pin(external_clock_pin),
    .cap_pin(capture_input_pin)
  );
  // tick sources, irq counts and p period
  always @(posedge aclk)
  begin
    cyc <= cyc + 32'h1;
    high_clock_tick <= ~cyc[0];
    time_base_tick <= (cyc[3:0] == 4'hF);
    if (match_a_irq === 1'b1)
      a_n++;
    if (match_p_irq === 1'b1)
    begin
      p_n++;
      p_gap <= cyc - p_last;
      p_last <= cyc;
    end
  end
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // spent bound is a mismatch; the extra edge spaces requests
  task automatic tmo(input int lim);
    if (k >= lim)
    begin
      n_fail++;
      wrap_up();
    end
    @(posedge aclk);
  endtask
  // one axi4-lite write (w=1) or read, held until answered
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 || s_axi_rvalid === 1'b1) break;
    end
    rd_d = s_axi_rdata;
    rs_d = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    tmo(50);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK(rd_d, e)
  endtask
  // one train of n slow pulses on the clock pin
  task automatic kick(input logic [3:0] n);
    burst <= 1'b1;
    n_pulse <= n;
    @(posedge aclk);
    burst <= 1'b0;
  endtask
  // byte buffer order: stale low until a high access moves it
  task automatic t_bytes();
    rc(6'h20, 32'h0);
    `CHK(rs_d, RESP_SLVERR)
    bus(1, OFS_CMPA_LO, 32'h5A);
    `CHK(rs_d, RESP_OKAY)
    rc(OFS_CMPA_LO, 32'h5A);
    rc(OFS_CMPA_HI, 32'h0);
    rc(OFS_CMPA_LO, 32'h0);
    bus(1, OFS_CMPA_LO, 32'h5A);
    bus(1, OFS_CMPA_HI, 32'h2);
    rc(OFS_CMPA_HI, 32'h2);
    rc(OFS_CMPA_LO, 32'h5A);
  endtask
  // p period for each internal source and some p codes
  task automatic t_clk();
    int cf[8][3] = '{'{0, 1, 512}, '{1, 1, 128}, '{2, 1, 4096}, '{3, 1, 16384},
                     '{4, 1, 2048}, '{5, 1, 2048}, '{1, 0, 1024}, '{1, 3, 384}};
    for (int i = 0; i < 8; i++)
    begin
      bus(1, OFS_CTRL0, {25'h0, cf[i][0][2:0], 1'b1, cf[i][1][2:0]});
      @(negedge aclk) p_n = 0;
      for (k = 0; k < 40000 && p_n < 2; k++) @(posedge aclk);
      tmo(40000);
      `CHK(p_gap, cf[i][2])
      bus(1, OFS_CTRL0, 32'h0);
    end
  endtask
  // compare output low, high, toggle; a match clears at 10
  task automatic t_cmp();
    `CHK(timer_output_oe, 1'b0)
    bus(1, OFS_PINSEL, 32'h7);
    bus(1, OFS_CMPA_LO, 32'hA);
    bus(1, OFS_CMPA_HI, 32'h0);
    for (int f = 1; f < 4; f++)
    begin
      bus(1, OFS_CTRL1, {26'h0, f[1:0], f != 2, 3'h1});
      bus(1, OFS_CTRL0, 32'h18);
      `CHK(timer_output_pin, f != 2)
      @(negedge aclk) a_n = 0;
      for (k = 0; k < 30 && a_n < 1; k++) @(posedge aclk);
      tmo(30);
      `CHK(timer_output_pin, f == 2)
      @(negedge aclk) a_n = 0;
      repeat (100) @(posedge aclk);
      // look off the edge so the last pulse is surely counted
      @(negedge aclk);
      `CHK(a_n, 10)
      bus(1, OFS_CTRL0, 32'h0);
    end
    `CHK(timer_output_oe, 1'b1)
  endtask
  // external clock: third active edge matches a at 3
  task automatic t_ext();
    bus(1, OFS_CMPA_LO, 32'h3);
    bus(1, OFS_CMPA_HI, 32'h0);
    bus(1, OFS_CTRL1, 32'hC1);
    for (int s = 6; s < 8; s++)
    begin
      bus(1, OFS_CTRL0, {25'h0, s[2:0], 4'h8});
      @(negedge aclk) a_n = 0;
      kick(4'h3);
      repeat (43) @(posedge aclk);
      `CHK(a_n, int'(s == 6))
      repeat (30) @(posedge aclk);
      `CHK(a_n, 1)
      bus(1, OFS_CTRL0, 32'h0);
    end
  endtask
  // capture edges: rise, fall, both, none over one pin pulse
  task automatic t_cap();
    for (int f = 0; f < 4; f++)
    begin
      bus(1, OFS_CTRL1, {24'h0, 2'h1, f[1:0], 4'h0});
      bus(1, OFS_CTRL0, 32'h18);
      @(negedge aclk) a_n = 0;
      cap_lvl <= 1'b1;
      repeat (9) @(posedge aclk);
      cap_lvl <= 1'b0;
      repeat (9) @(posedge aclk);
      `CHK(a_n, f == 2 ? 2 : int'(f < 2))
      bus(1, OFS_CTRL0, 32'h0);
    end
  endtask
  // pwm duty in both polarities, single pulse, paused count read
  task automatic t_pwm();
    int h;
    bus(1, OFS_CMPA_LO, 32'h20);
    bus(1, OFS_CMPA_HI, 32'h0);
    for (int q = 0; q < 3; q++)
    begin
      bus(1, OFS_CTRL1, q == 2 ? 32'hB9 : 32'hA8 | (q << 2));
      bus(1, OFS_CTRL0, 32'h19);
      if (q == 2)
        kick(4'h1);
      h = 0;
      repeat (128)
      begin
        @(negedge aclk);
        h += int'(timer_output_pin === 1'b1);
      end
      `CHK(h, q == 1 ? 96 : 32)
      bus(1, OFS_CTRL0, 32'h0);
    end
    // five counted edges, then two more while paused
    bus(1, OFS_CTRL1, 32'hC0);
    bus(1, OFS_CTRL0, 32'h68);
    kick(4'h5);
    repeat (90) @(posedge aclk);
    bus(1, OFS_CTRL0, 32'hE8);
    kick(4'h2);
    repeat (40) @(posedge aclk);
    rc(OFS_CNT_HI, 32'h0);
    rc(OFS_CNT_LO, 32'h5);
    bus(1, OFS_CTRL0, 32'h0);
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_bytes();
    t_clk();
    t_cmp();
    t_ext();
    t_cap();
    t_pwm();
    wrap_up();
  end
endmodule // timer_module_common_core_test
